// File: hw/rddc_top.sv
// down-converter core: register file, sample delay, mixer and decimation chain
// assumes one real converter sample per clk and a byte-wide register port
// Operation
// - A complex oscillator sequence is made whose frequency comes from a 32-bit tuning word.
// - Real input samples are multiplied by the oscillator to bring the chosen carrier to 0 Hz.
// - Eight phase accumulators, one per preset, all advance every cycle so switching is immediate.
// - Source bit 0 at 0x20C picks pin selection when 0 and register selection when 1.
// - The 3-bit field at 0x20D bits 2:0 names the active preset under register selection.
// - In basic mode each accumulator adds its 32-bit tuning word once per clock.
// - In rational mode the accumulators land exactly on whole turns every 128 times the divisor cycles.
// - Each preset's 16-bit phase offset is left justified into 32 bits and added to its accumulator.
// - A sample delay of 0 up to the decimation factor minus half a sample is set in half-sample steps.
// - Overall decimation is 4, 8, 10, 16, 20 or 32 with complex samples through every stage.
// - Each output is 15-bit I and 15-bit Q plus two range bits at clock over decimation.
// - Stages chain per setting: d19 d55, d11 d15 d55, d11 d139, d7 d11 d15 d55, d7 d11 d139, d7 d7 d11 d15 d55.
// - The upper 15 bits of each word carry data and the LSB carries the range flag.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "rddc_regs.svh"
module rddc_top (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic signed [11:0] adc_sample,
	input  wire logic [2:0]         preset_select_pins,
	input  wire logic               range_flag_high,
	input  wire logic               range_flag_low,
	input  wire logic [11:0]        reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [7:0]              reg_rdata,
	output logic [15:0]             out_i,
	output logic [15:0]             out_q,
	output logic                    out_vld
);
	// register file
	logic             src_ff;
	logic [2:0]       preset_index_field_ff;
	logic             mode_ff;
	logic [2:0]       dec_ff;
	logic [5:0]       dly_ff;
	logic [15:0]      rdiv_ff;
	logic [7:0][31:0] freq_ff;
	logic [7:0][15:0] phase_ff;
	logic [7:0]       rdata_ff;

	// datapath state
	logic signed [11:0]  dmem [0:63];
	logic [5:0]          wr_ptr_ff;
	rddc_pkg::rddc_smp_t mix_i_ff;
	rddc_pkg::rddc_smp_t mix_q_ff;
	logic                mix_vld_ff;
	logic [3:0]          fill_ff;
	logic [15:0]         out_i_ff;
	logic [15:0]         out_q_ff;
	logic                out_vld_ff;

	function automatic logic [5:0] dec_factor(input logic [2:0] c);
		case (c)
			rddc_pkg::dec8:  dec_factor = 6'h08;
			rddc_pkg::dec10: dec_factor = 6'h0a;
			rddc_pkg::dec16: dec_factor = 6'h10;
			rddc_pkg::dec20: dec_factor = 6'h14;
			rddc_pkg::dec32: dec_factor = 6'h20;
			default:         dec_factor = 6'h04;
		endcase
	endfunction

	// bit 5 picks d139 over d55; bits 4:0 enable d15, d19, d11, d7b, d7a
	function automatic logic [5:0] stage_use(input logic [2:0] c);
		case (c)
			rddc_pkg::dec8:  stage_use = 6'b010100;
			rddc_pkg::dec10: stage_use = 6'b100100;
			rddc_pkg::dec16: stage_use = 6'b010101;
			rddc_pkg::dec20: stage_use = 6'b100101;
			rddc_pkg::dec32: stage_use = 6'b010111;
			default:         stage_use = 6'b001000;
		endcase
	endfunction

	// address decode
	wire       hit_src   = reg_addr == `RDDC_ADDR_SRC;
	wire       hit_sel   = reg_addr == `RDDC_ADDR_SEL;
	wire       hit_mode  = reg_addr == `RDDC_ADDR_MODE;
	wire       hit_dec   = reg_addr == `RDDC_ADDR_DEC;
	wire       hit_dly   = reg_addr == `RDDC_ADDR_DLY;
	wire       hit_stat  = reg_addr == `RDDC_ADDR_STAT;
	wire       hit_freq  = (reg_addr & `RDDC_MASK_FREQ) == `RDDC_ADDR_FREQ;
	wire       hit_phase = (reg_addr & `RDDC_MASK_PHASE) == `RDDC_ADDR_PHASE;
	wire       hit_rdiv  = (reg_addr & `RDDC_MASK_RDIV) == `RDDC_ADDR_RDIV;
	wire [2:0] f_idx     = reg_addr[4:2];
	wire [4:0] f_bit     = {reg_addr[1:0], 3'h0};
	wire [2:0] p_idx     = reg_addr[3:1];
	wire [3:0] p_bit     = {reg_addr[0], 3'h0};
	wire [3:0] r_bit     = {reg_addr[0], 3'h0};
	wire       filled    = fill_ff == `RDDC_FILL_OUTS;

	// preset choice: pins or register field
	wire [2:0] active_sel = src_ff ? preset_index_field_ff : preset_select_pins;

	wire [7:0] nxt_rdata =
		hit_src   ? {7'h00, src_ff} :
		hit_sel   ? {5'h00, preset_index_field_ff} :
		hit_mode  ? {7'h00, mode_ff} :
		hit_dec   ? {5'h00, dec_ff} :
		hit_dly   ? {2'h0, dly_ff} :
		hit_stat  ? {4'h0, filled, active_sel} :
		hit_freq  ? freq_ff[f_idx][f_bit +: 8] :
		hit_phase ? phase_ff[p_idx][p_bit +: 8] :
		hit_rdiv  ? rdiv_ff[r_bit +: 8] :
		8'h00;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			src_ff                <= `RDDC_RST_SRC;
			preset_index_field_ff <= `RDDC_RST_SEL;
			mode_ff               <= `RDDC_RST_MODE;
			dec_ff                <= `RDDC_RST_DEC;
			dly_ff                <= `RDDC_RST_DLY;
			rdiv_ff               <= `RDDC_RST_RDIV;
			freq_ff               <= {8{`RDDC_RST_FREQ}};
			phase_ff              <= {8{`RDDC_RST_PHASE}};
		end else if (reg_wr) begin
			if (hit_src)
				src_ff <= reg_wdata[`RDDC_SRC_BIT];
			if (hit_sel)
				preset_index_field_ff <= reg_wdata[2:0];
			if (hit_mode)
				mode_ff <= reg_wdata[0];
			if (hit_dec)
				dec_ff <= reg_wdata[2:0];
			if (hit_dly)
				dly_ff <= reg_wdata[5:0];
			if (hit_freq)
				freq_ff[f_idx][f_bit +: 8] <= reg_wdata;
			if (hit_phase)
				phase_ff[p_idx][p_bit +: 8] <= reg_wdata;
			if (hit_rdiv)
				rdiv_ff[r_bit +: 8] <= reg_wdata;
		end
	end

	// read data only in the cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
	end

	// oscillator
	logic signed [11:0] nco_cos;
	logic signed [11:0] nco_sin;

	rddc_nco u_nco (
		.clk                   (clk),
		.nrst                  (nrst),
		.preset_tuning_word    (freq_ff),
		.preset_phase_offset   (phase_ff),
		.active_sel            (active_sel),
		.rational_en           (mode_ff),
		.rational_step_divisor (rdiv_ff),
		.nco_cos               (nco_cos),
		.nco_sin               (nco_sin)
	);

	// sample delay in half steps, clamped to 2*D-1 half samples
	wire [5:0] dec_d   = dec_factor(dec_ff);
	wire [6:0] dly_max = {dec_d, 1'b0} - 7'h01;
	wire [5:0] dly_eff = ({1'b0, dly_ff} > dly_max) ? dly_max[5:0] : dly_ff;
	wire [5:0] tap_a   = wr_ptr_ff - 6'h01 - {1'b0, dly_eff[5:1]};
	wire [5:0] tap_b   = tap_a - 6'h01;
	wire signed [12:0] smp_a = 13'(dmem[tap_a]);
	wire signed [12:0] smp_b = 13'(dmem[tap_b]);
	// half step is the sum of two neighbours; whole steps double to keep one scale
	wire signed [12:0] dsum  = dly_eff[0] ? smp_a + smp_b : smp_a + smp_a;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_ff <= 6'h00;
			for (int k = 0; k < 64; k++)
				dmem[k] <= 12'sh000;
		end else begin
			dmem[wr_ptr_ff] <= adc_sample;
			wr_ptr_ff       <= wr_ptr_ff + 6'h01;
		end
	end

	// mixer: x*cos on I, -x*sin on Q
	wire signed [24:0] prod_i = dsum * nco_cos;
	wire signed [24:0] prod_q = dsum * nco_sin;
	wire rddc_pkg::rddc_smp_t mq = prod_q[23:6];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mix_i_ff   <= 18'sh0;
			mix_q_ff   <= 18'sh0;
			mix_vld_ff <= 1'b0;
		end else begin
			mix_i_ff   <= prod_i[23:6];
			mix_q_ff   <= -mq;
			mix_vld_ff <= 1'b1;
		end
	end

	// decimation chain: d7a, d7b, d11, d19, d15, then d55 or d139
	wire [5:0]           use_mask = stage_use(dec_ff);
	logic                ch_v [0:5];
	rddc_pkg::rddc_smp_t ch_i [0:5];
	rddc_pkg::rddc_smp_t ch_q [0:5];

	assign ch_v[0] = mix_vld_ff;
	assign ch_i[0] = mix_i_ff;
	assign ch_q[0] = mix_q_ff;

	for (genvar g = 0; g < 5; g++) begin : g_st
		rddc_stage #(.DEC(2)) u_st (
			.clk       (clk),
			.nrst      (nrst),
			.use_stage (use_mask[g]),
			.in_vld    (ch_v[g]),
			.in_i      (ch_i[g]),
			.in_q      (ch_q[g]),
			.out_vld   (ch_v[g+1]),
			.out_i     (ch_i[g+1]),
			.out_q     (ch_q[g+1])
		);
	end

	logic                v55;
	logic                v139;
	rddc_pkg::rddc_smp_t i55;
	rddc_pkg::rddc_smp_t q55;
	rddc_pkg::rddc_smp_t i139;
	rddc_pkg::rddc_smp_t q139;

	rddc_stage #(.DEC(2)) u_s55 (
		.clk       (clk),
		.nrst      (nrst),
		.use_stage (!use_mask[5]),
		.in_vld    (ch_v[5] && !use_mask[5]),
		.in_i      (ch_i[5]),
		.in_q      (ch_q[5]),
		.out_vld   (v55),
		.out_i     (i55),
		.out_q     (q55)
	);

	rddc_stage #(.DEC(5)) u_s139 (
		.clk       (clk),
		.nrst      (nrst),
		.use_stage (use_mask[5]),
		.in_vld    (ch_v[5] && use_mask[5]),
		.in_i      (ch_i[5]),
		.in_q      (ch_q[5]),
		.out_vld   (v139),
		.out_i     (i139),
		.out_q     (q139)
	);

	wire                      fin_v = use_mask[5] ? v139 : v55;
	wire rddc_pkg::rddc_smp_t fin_i = use_mask[5] ? i139 : i55;
	wire rddc_pkg::rddc_smp_t fin_q = use_mask[5] ? q139 : q55;

	// changing decimation leaves stale partial sums, so refill before trusting output
	wire dec_chg = reg_wr && hit_dec;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			fill_ff <= 4'h0;
		else if (dec_chg)
			fill_ff <= 4'h0;
		else if (fin_v && !filled)
			fill_ff <= fill_ff + 4'h1;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_i_ff   <= 16'h0000;
			out_q_ff   <= 16'h0000;
			out_vld_ff <= 1'b0;
		end else begin
			out_vld_ff <= fin_v && filled && !dec_chg;
			if (fin_v) begin
				out_i_ff <= {fin_i[17:3], range_flag_high};
				out_q_ff <= {fin_q[17:3], range_flag_low};
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign out_i     = out_i_ff;
	assign out_q     = out_q_ff;
	assign out_vld   = out_vld_ff;
endmodule

// File: hw/rddc_regs.svh
// register offsets, reset values and fixed counts of the down-converter
// assumes a byte-wide register port with a 12-bit byte address
`ifndef RDDC_REGS_SVH
`define RDDC_REGS_SVH
`define RDDC_ADDR_SRC    12'h20c
`define RDDC_ADDR_SEL    12'h20d
`define RDDC_ADDR_FREQ   12'h220
`define RDDC_MASK_FREQ   12'hfe0
`define RDDC_ADDR_PHASE  12'h240
`define RDDC_MASK_PHASE  12'hff0
`define RDDC_ADDR_RDIV   12'h250
`define RDDC_MASK_RDIV   12'hffe
`define RDDC_ADDR_MODE   12'h252
`define RDDC_ADDR_DEC    12'h253
`define RDDC_ADDR_DLY    12'h254
`define RDDC_ADDR_STAT   12'h255
`define RDDC_SRC_BIT     0
`define RDDC_RST_SRC     1'h0
`define RDDC_RST_SEL     3'h0
`define RDDC_RST_MODE    1'h0
`define RDDC_RST_DEC     3'h0
`define RDDC_RST_DLY     6'h00
`define RDDC_RST_RDIV    16'h0000
`define RDDC_RST_FREQ    32'h00000000
`define RDDC_RST_PHASE   16'h0000
`define RDDC_RDIV_SHIFT  7
`define RDDC_FILL_OUTS   4'h4
`endif

// File: hw/rddc_pkg.sv
// shared types of the down-converter
// assumes the offsets and counts come from rddc_regs.svh
package rddc_pkg;
	typedef enum logic [2:0] {dec4, dec8, dec10, dec16, dec20, dec32} rddc_dec_e;
	typedef logic signed [17:0] rddc_smp_t;
endpackage

// File: hw/rddc_nco.sv
// eight-preset complex oscillator with basic and rational stepping
// assumes one step per clk and tuning words held stable by the register file
`timescale 1ns/100ps
`include "rddc_regs.svh"
module rddc_nco (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic [7:0][31:0]   preset_tuning_word,
	input  wire logic [7:0][15:0]   preset_phase_offset,
	input  wire logic [2:0]         active_sel,
	input  wire logic               rational_en,
	input  wire logic [15:0]        rational_step_divisor,
	output logic signed [11:0]      nco_cos,
	output logic signed [11:0]      nco_sin
);
	logic [7:0][31:0] acc_ff;
	logic [22:0]      per_ff;
	logic signed [11:0] cos_ff;
	logic signed [11:0] sin_ff;

	function automatic logic [10:0] qsin(input logic [3:0] i);
		case (i)
			4'h0: qsin = 11'h000;
			4'h1: qsin = 11'h0c9;
			4'h2: qsin = 11'h18f;
			4'h3: qsin = 11'h252;
			4'h4: qsin = 11'h30f;
			4'h5: qsin = 11'h3c5;
			4'h6: qsin = 11'h471;
			4'h7: qsin = 11'h513;
			4'h8: qsin = 11'h5a7;
			4'h9: qsin = 11'h62e;
			4'ha: qsin = 11'h6a6;
			4'hb: qsin = 11'h70d;
			4'hc: qsin = 11'h763;
			4'hd: qsin = 11'h7a7;
			4'he: qsin = 11'h7d8;
			default: qsin = 11'h7f5;
		endcase
	endfunction

	// coarse 64-point sine; quarter table mirrored by quadrant
	function automatic logic signed [11:0] sinv(input logic [5:0] p);
		logic [3:0]         i;
		logic signed [11:0] m;
		i = p[4] ? ~p[3:0] : p[3:0];
		m = $signed({1'b0, qsin(i)});
		sinv = p[5] ? -m : m;
	endfunction

	wire [22:0] per_len = 23'(rational_step_divisor) << `RDDC_RDIV_SHIFT;
	// after 128*divisor steps every word 2^25*N/divisor has turned whole cycles
	wire        wrap    = rational_en && (per_len != 23'h0) && (per_ff == per_len - 23'h1);
	wire [31:0] ph      = acc_ff[active_sel] + {preset_phase_offset[active_sel], 16'h0000};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_ff <= '0;
			per_ff <= 23'h0;
		end else begin
			per_ff <= (wrap || !rational_en) ? 23'h0 : per_ff + 23'h1;
			for (int k = 0; k < 8; k++) begin
				// every preset runs, selected or not
				acc_ff[k] <= wrap ? 32'h0 : acc_ff[k] + preset_tuning_word[k];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cos_ff <= 12'sh000;
			sin_ff <= 12'sh000;
		end else begin
			cos_ff <= sinv(ph[31:26] + 6'h10);
			sin_ff <= sinv(ph[31:26]);
		end
	end

	assign nco_cos = cos_ff;
	assign nco_sin = sin_ff;
endmodule

// File: hw/rddc_stage.sv
// one complex decimating filter stage with bypass
// assumes samples arrive with a one-cycle valid; coefficient shaping is a plain boxcar
`timescale 1ns/100ps
module rddc_stage #(
	parameter int DEC = 2
) (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               use_stage,
	input  wire logic               in_vld,
	input  wire rddc_pkg::rddc_smp_t in_i,
	input  wire rddc_pkg::rddc_smp_t in_q,
	output logic                    out_vld,
	output rddc_pkg::rddc_smp_t     out_i,
	output rddc_pkg::rddc_smp_t     out_q
);
	logic [2:0]          cnt_ff;
	logic signed [20:0]  acc_i_ff;
	logic signed [20:0]  acc_q_ff;
	logic                vld_ff;
	rddc_pkg::rddc_smp_t i_ff;
	rddc_pkg::rddc_smp_t q_ff;

	// gain near one: 13/64 stands in for 1/5 to avoid a divider
	function automatic rddc_pkg::rddc_smp_t scale(input logic signed [20:0] s);
		logic signed [24:0] t;
		t = s * 25'sd13;
		scale = (DEC == 2) ? 18'(s >>> 1) : 18'(t >>> 6);
	endfunction

	wire                last  = cnt_ff == 3'(DEC - 1);
	wire signed [20:0]  sum_i = acc_i_ff + 21'(in_i);
	wire signed [20:0]  sum_q = acc_q_ff + 21'(in_q);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff   <= 3'h0;
			acc_i_ff <= 21'sh0;
			acc_q_ff <= 21'sh0;
			vld_ff   <= 1'b0;
			i_ff     <= 18'sh0;
			q_ff     <= 18'sh0;
		end else if (!use_stage) begin
			cnt_ff   <= 3'h0;
			acc_i_ff <= 21'sh0;
			acc_q_ff <= 21'sh0;
			vld_ff   <= in_vld;
			i_ff     <= in_i;
			q_ff     <= in_q;
		end else begin
			vld_ff <= in_vld && last;
			if (in_vld && last) begin
				cnt_ff   <= 3'h0;
				acc_i_ff <= 21'sh0;
				acc_q_ff <= 21'sh0;
				i_ff     <= scale(sum_i);
				q_ff     <= scale(sum_q);
			end else if (in_vld) begin
				cnt_ff   <= cnt_ff + 3'h1;
				acc_i_ff <= sum_i;
				acc_q_ff <= sum_q;
			end
		end
	end

	assign out_vld = vld_ff;
	assign out_i   = i_ff;
	assign out_q   = q_ff;
endmodule

// File: tb/rddc_sink.sv
// receiving side of the sample stream: takes each flagged complex sample
// assumes rddc_top outputs; never back-pressures, like the real link
`timescale 1ns/100ps
module rddc_sink (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [15:0] out_i,
	input  wire logic [15:0] out_q,
	input  wire logic        out_vld,
	output logic      [15:0] got_cnt,
	output logic      [7:0]  gap,
	output logic      [15:0] smp_i,
	output logic      [15:0] smp_q
);
	logic [7:0] run_ff;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_ff  <= 8'h00;
			got_cnt <= 16'h0000;
			gap     <= 8'h00;
			smp_i   <= 16'h0000;
			smp_q   <= 16'h0000;
		end else begin
			run_ff <= out_vld ? 8'h01 : run_ff + 8'h01;
			if (out_vld) begin
				got_cnt <= got_cnt + 16'h0001;
				gap     <= run_ff;
				smp_i   <= out_i; // i and q kept as one complex sample
				smp_q   <= out_q;
			end
		end
	end
endmodule

// File: tb/rddc_top_properties.sv
// port assertions of the down-converter
// assumes binding to rddc_top; register shadows track only writes it sees
`timescale 1ns/100ps
module rddc_top_checker (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [2:0]  preset_select_pins,
	input wire logic        range_flag_high,
	input wire logic        range_flag_low,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [15:0] out_i,
	input wire logic [15:0] out_q,
	input wire logic        out_vld
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic       src_ff;
	logic [2:0] sel_ff;
	logic [2:0] dec_ff;
	logic [5:0] gap_ff;
	logic       seen_ff;
	logic [5:0] dfac;
	wire wr_dec = reg_wr && reg_addr == 12'h253;
	wire wr_dly = reg_wr && reg_addr == 12'h254;
	assign dfac = dec_ff == 3'h1 ? 6'h08 : dec_ff == 3'h2 ? 6'h0a : dec_ff == 3'h3 ? 6'h10 :
		dec_ff == 3'h4 ? 6'h14 : dec_ff == 3'h5 ? 6'h20 : 6'h04;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			src_ff  <= 1'b0;
			sel_ff  <= 3'h0;
			dec_ff  <= 3'h0;
			gap_ff  <= 6'h00;
			seen_ff <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == 12'h20c) src_ff <= reg_wdata[0];
			if (reg_wr && reg_addr == 12'h20d) sel_ff <= reg_wdata[2:0];
			if (wr_dec) dec_ff <= reg_wdata[2:0];
			// saturate so a long stall never wraps into a false period
			gap_ff  <= out_vld ? 6'h01 : (gap_ff == 6'h3f ? gap_ff : gap_ff + 6'h01);
			seen_ff <= (wr_dec || wr_dly) ? 1'b0 : (out_vld ? 1'b1 : seen_ff);
		end
	end
	sequence s_dec_wr;
		wr_dec;
	endsequence
	property p_rb(a, m);
		logic [7:0] v;
		(reg_wr && reg_addr == a, v = reg_wdata & m) ##[1:3] (reg_rd && reg_addr == a) |=> reg_rdata == v;
	endproperty
	a_src_readback: assert property (p_rb(12'h20c, 8'h01)) else $error("source bit readback wrong");
	a_sel_readback: assert property (p_rb(12'h20d, 8'h07)) else $error("preset field readback wrong");
	a_active_preset: assert property (reg_rd && reg_addr == 12'h255 |=> reg_rdata[7:4] == 4'h0 &&
		reg_rdata[2:0] == ($past(src_ff) ? $past(sel_ff) : $past(preset_select_pins)))
		else $error("active preset wrong");
	a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("read data outside slot");
	a_unmapped_zero: assert property (reg_rd && reg_addr[11:8] != 4'h2 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_vld_spacing: assert property (out_vld |=> !out_vld [*3]) else $error("samples too close");
	a_vld_period: assert property (out_vld && seen_ff |-> gap_ff == dfac) else $error("output rate wrong");
	a_range_lsb: assert property (out_vld |-> out_i[0] == $past(range_flag_high) &&
		out_q[0] == $past(range_flag_low)) else $error("range bits misplaced");
	a_refill_quiet: assert property (s_dec_wr |=> !out_vld [*8]) else $error("sample flagged during refill");
	a_reset_quiet: assert property ($rose(nrst) |-> !out_vld && reg_rdata == 8'h00)
		else $error("outputs active after reset");
endmodule
bind rddc_top rddc_top_checker u_chk (
	.clk(clk), .nrst(nrst), .preset_select_pins(preset_select_pins), .range_flag_high(range_flag_high),
	.range_flag_low(range_flag_low), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_i(out_i), .out_q(out_q), .out_vld(out_vld)
);

// File: tb/rddc_top_bench.sv
// register and stream tests of the down-converter
// assumes the sink model as far side and a constant positive converter input
`timescale 1ns/100ps
module rddc_top_bench;
	logic               clk;
	logic               nrst;
	logic signed [11:0] adc_sample;
	logic [2:0]         pins;
	logic               rfh;
	logic               rfl;
	logic [11:0]        reg_addr;
	logic [7:0]         reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [7:0]         reg_rdata;
	logic [15:0]        out_i;
	logic [15:0]        out_q;
	logic               out_vld;
	logic [15:0]        got_cnt;
	logic [7:0]         gap;
	logic [15:0]        smp_i;
	logic [15:0]        smp_q;
	logic [7:0]         rd_val;
	logic [15:0]        ref_i;
	logic [15:0]        ref_q;
	logic [7:0]         pat [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
	// codes 6 and 7 fall back to decimation by 4
	logic [7:0]         dtab [8] = '{8'h04, 8'h08, 8'h0a, 8'h10, 8'h14, 8'h20, 8'h04, 8'h04};
	int                 n_mismatch;
	int                 samples_checked;
	int                 cycles;
	rddc_top dut (.clk(clk), .nrst(nrst), .adc_sample(adc_sample), .preset_select_pins(pins),
		.range_flag_high(rfh), .range_flag_low(rfl), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_i(out_i), .out_q(out_q), .out_vld(out_vld));
	rddc_sink u_sink (.clk(clk), .nrst(nrst), .out_i(out_i), .out_q(out_q), .out_vld(out_vld),
		.got_cnt(got_cnt), .gap(gap), .smp_i(smp_i), .smp_q(smp_q));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic close_out();
		$display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// bounded run: all tests need well under 10000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		check(name, {8'h00, v}, {8'h00, exp});
	endtask
	// waits for n more flagged samples; a stall counts as a mismatch
	task automatic wait_smp(input int n);
		logic [15:0] goal;
		int          k;
		goal = got_cnt + 16'(n);
		k = 0;
		while (got_cnt !== goal && k < 400 * n) begin
			@(posedge clk);
			k++;
		end
		check("sample wait", got_cnt, goal);
	endtask
	initial begin
		nrst = 1'b0;
		adc_sample = 12'sh400;
		pins = 3'h0;
		rfh = 1'b0;
		rfl = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_mismatch = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		rd_chk("source", 12'h20c, 8'h00);
		rd_chk("index", 12'h20d, 8'h00);
		rd_chk("decim", 12'h253, 8'h00);
		rd_chk("unmapped", 12'h000, 8'h00);
		wr(12'h20c, 8'hff);
		rd_chk("source", 12'h20c, 8'h01);
		wr(12'h20d, 8'hfd);
		rd_chk("index", 12'h20d, 8'h05);
		@(posedge clk);
		pins <= 3'h3;
		rd(12'h255, rd_val);
		check("active reg", {13'h0, rd_val[2:0]}, 16'h0005);
		wr(12'h20c, 8'h00);
		rd(12'h255, rd_val);
		check("active pins", {13'h0, rd_val[2:0]}, 16'h0003);
		for (int k = 0; k < 4; k++) wr(12'h228 + 12'(k), pat[k]);
		for (int k = 0; k < 4; k++) rd_chk("tuning", 12'h228 + 12'(k), pat[k]);
		wr(12'h242, 8'h00);
		wr(12'h243, 8'h40);
		rd_chk("phase", 12'h243, 8'h40);
		wr(12'h250, 8'h80); // 1920 stays within the divisor limit
		wr(12'h251, 8'h07);
		rd_chk("divisor", 12'h251, 8'h07);
		// preset 0 has zero tuning and phase, so the mixer sees cos 0
		@(posedge clk);
		pins <= 3'h0;
		rfh  <= 1'b1;
		rfl  <= 1'b0;
		wait_smp(6);
		check("q at dc", {1'b0, smp_q[15:1]}, 16'h0000);
		check("i sign", {15'h0, smp_i[15]}, 16'h0000);
		check("i nonzero", {15'h0, smp_i[15:1] != 15'h0}, 16'h0001);
		check("i range", {15'h0, smp_i[0]}, 16'h0001);
		check("q range", {15'h0, smp_q[0]}, 16'h0000);
		// quarter-turn offset on preset 1 swings q negative
		@(posedge clk);
		pins <= 3'h1;
		wait_smp(6);
		check("q sign", {15'h0, smp_q[15]}, 16'h0001);
		@(posedge clk);
		pins <= 3'h0;
		for (int c = 0; c < 8; c++) begin
			wr(12'h253, 8'(c));
			rd_chk("decim", 12'h253, 8'(c));
			wait_smp(6);
			check("rate", {8'h00, gap}, {8'h00, dtab[c]});
		end
		wr(12'h254, 8'h3f);
		rd_chk("delay", 12'h254, 8'h3f);
		wait_smp(3);
		@(posedge clk);
		nrst <= 1'b0; // reset re-initialises the link after tuning and phase changes
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd_chk("decim rst", 12'h253, 8'h00);
		rd_chk("delay rst", 12'h254, 8'h00);
		repeat (10) @(posedge clk);
		check("refill", got_cnt, 16'h0000);
		wait_smp(2);
		// rational mode, divisor 1: word 2^25 is N = 1, one whole turn per 128 clocks
		wr(12'h223, 8'h02); // preset 0
		rd_chk("tuning", 12'h223, 8'h02);
		// preset 3 starts four clocks later, so only the forced wrap can line it up
		wr(12'h22f, 8'h02);
		wr(12'h250, 8'h01);
		wr(12'h252, 8'h01);
		rd_chk("mode", 12'h252, 8'h01);
		wait_smp(40);
		ref_i = smp_i;
		ref_q = smp_q;
		pins <= 3'h3;
		// 32 samples at decimation 4 are exactly one 128-clock period later
		wait_smp(32);
		check("rational i", smp_i, ref_i);
		check("rational q", smp_q, ref_q);
		close_out();
	end
endmodule
